// [rtl/dbg_status_pkg.sv]
// Package of constants and carrier types for the debug status block.
package dbg_status_pkg;

    // Width of the APB address seen by this block.
    localparam int unsigned ADDR_W = 12;

    // Register indices; byte address is four times the index.
    localparam int unsigned IDX_CTRL   = 'h100;
    localparam int unsigned IDX_IRQ_ST = 'h101;
    localparam int unsigned IDX_IRQ_MK = 'h102;
    localparam int unsigned IDX_EVENT  = 'h10a;
    localparam int unsigned IDX_STATUS = 'h10b;

    // Byte addresses derived from the indices.
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = ADDR_W'(IDX_CTRL * 4);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ST = ADDR_W'(IDX_IRQ_ST * 4);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MK = ADDR_W'(IDX_IRQ_MK * 4);
    localparam logic [ADDR_W-1:0] ADDR_EVENT  = ADDR_W'(IDX_EVENT * 4);
    localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(IDX_STATUS * 4);

    // Field positions in the status register.
    localparam int unsigned TF_BIT   = 7;
    localparam int unsigned PA_BIT   = 4;
    localparam int unsigned SSF_LSB  = 0;
    localparam int unsigned SSF_W    = 3;

    // Field positions in the event flag register.
    localparam int unsigned EEV_BIT  = 4;
    localparam int unsigned HIT_LSB  = 0;
    localparam int unsigned HIT_W    = 4;

    // Session enable bit in the control register.
    localparam int unsigned ARM_BIT  = 0;

    // Interrupt status and mask layout.
    localparam int unsigned IRQ_W        = 4;
    localparam int unsigned IRQ_FULL_BIT = 0;
    localparam int unsigned IRQ_EXT_BIT  = 1;
    localparam int unsigned IRQ_END_BIT  = 2;
    localparam int unsigned IRQ_PROF_BIT = 3;

    // Sequencer state codes as reported to software.
    localparam logic [SSF_W-1:0] SEQ_S0 = 3'h0;
    localparam logic [SSF_W-1:0] SEQ_S1 = 3'h1;
    localparam logic [SSF_W-1:0] SEQ_S2 = 3'h2;
    localparam logic [SSF_W-1:0] SEQ_S3 = 3'h3;

    // Reset values.
    localparam logic [7:0]       REG_RST  = 8'h00;
    localparam logic [31:0]      RDATA_RST = 32'h0000_0000;

    // Default trace depth in lines; counter is seven bits wide.
    localparam int unsigned TRACE_LINES = 64;
    localparam int unsigned CNT_W       = 7;

    // APB request from the master.
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
        logic [3:0]        pstrb;
    } apb_req_s;

    // APB answer to the master.
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

    // Event inputs from the rest of the debug unit.
    typedef struct packed {
        logic             trace_filled;
        logic             prof_entry;
        logic             prof_done;
        logic             ext_event;
        logic [HIT_W-1:0] cmp_hit;
        logic             seq_step;
        logic [1:0]       seq_state;
        logic             internal_end;
    } dbg_evt_s;

endpackage

// [rtl/debug_session_status.sv]
// Debug session status and event flags with an APB register port.
//
// Function
// - Set external event flag during session.
// - One comparator hit bit per channel.
// - Trace-full flag in status bit 7.
// - Trace full means every line valid.
// - Writing session enable one clears trace-full.
// - Of the resets, only power-on reset clears trace-full.
// - Profiling-active set on first profiling entry.
// - Profiling-active cleared when transmission finishes.
// - State field follows each sequencer transition while armed.
// - Software disarm keeps last state.
// - Internal end clears state field to 000.
// - Arming forces state field to 001.
// - State field is binary state number.
`timescale 1ns/1ps
`default_nettype none
module debug_session_status #(
    parameter int unsigned LINES = dbg_status_pkg::TRACE_LINES
) (
    // Clock and resets.
    input  wire logic                       clk_sys_in,
    input  wire logic                       rst_n_in,
    input  wire logic                       por_n_in,
    // APB slave port.
    input  wire dbg_status_pkg::apb_req_s   apb_req_in,
    output dbg_status_pkg::apb_rsp_s        apb_rsp_out,
    // Events from the rest of the debug unit.
    input  wire dbg_status_pkg::dbg_evt_s   evt_in,
    input  wire logic [6:0]                 trace_line_counter_in,
    // Status towards the debug unit and the system.
    output logic                            armed_out,
    output logic                            arm_pulse_out,
    output logic [6:0]                      valid_lines_out,
    output logic                            irq_out
);
    import dbg_status_pkg::*;

    // Bus decode.
    logic              setup_phase;   // First cycle of a transfer.
    logic              access_phase;  // Second cycle, write commits here.
    logic              wr_commit;     // Write that takes effect now.
    logic              lane0;         // Low byte lane is enabled.
    logic              hit_ctrl;      // Address hits control register.
    logic              hit_irq_st;    // Address hits interrupt status.
    logic              hit_irq_mk;    // Address hits interrupt mask.
    logic              hit_event;     // Address hits event flags.
    logic              hit_status;    // Address hits status register.
    logic              mapped;        // Any register is addressed.

    // Session control.
    logic              armed_q;       // Session enable bit.
    logic              arm_pulse;     // Software wrote a one to enable.
    logic              disarm_sw;     // Software wrote a zero to enable.
    logic              end_int;       // Internal event ended the session.

    // Flags.
    logic              trace_full;    // Trace buffer filled since arming.
    logic              prof_active;   // Profiling transmission running.
    logic [SSF_W-1:0]  seq_field;     // Sequencer state field.
    logic              ext_flag;      // External event seen.
    logic [HIT_W-1:0]  hit_flags;     // Comparator hit bits.
    logic              prof_done_evt; // Profiling stopped this cycle.

    // Interrupt logic.
    logic [IRQ_W-1:0]  irq_set;       // Events that raise status bits.
    logic [IRQ_W-1:0]  irq_clr;       // Write-one-to-clear mask.
    logic [IRQ_W-1:0]  irq_status;    // Sticky interrupt status.
    logic [IRQ_W-1:0]  irq_mask_q;    // Interrupt enable mask.

    // Read path.
    logic [7:0]        status_word;   // Assembled status byte.
    logic [7:0]        event_word;    // Assembled event byte.
    logic [31:0]       rdata_d;       // Read data for the next cycle.
    logic [31:0]       rdata_q;       // Registered read data.
    logic              slverr_q;      // Registered unmapped flag.
    logic [6:0]        valid_lines_q; // Registered valid line count.

    // Phase decode: the slave never inserts wait states.
    always_comb begin
        setup_phase  = apb_req_in.psel && !apb_req_in.penable;
        access_phase = apb_req_in.psel && apb_req_in.penable;
        lane0        = apb_req_in.pstrb[0];
    end

    // Address decode on the full byte address, misaligned is unmapped.
    always_comb begin
        hit_ctrl   = (apb_req_in.paddr == ADDR_CTRL);
        hit_irq_st = (apb_req_in.paddr == ADDR_IRQ_ST);
        hit_irq_mk = (apb_req_in.paddr == ADDR_IRQ_MK);
        hit_event  = (apb_req_in.paddr == ADDR_EVENT);
        hit_status = (apb_req_in.paddr == ADDR_STATUS);
        mapped     = hit_ctrl || hit_irq_st || hit_irq_mk ||
                     hit_event || hit_status;
    end

    // A write commits only in the access cycle of a mapped address.
    always_comb begin
        wr_commit = access_phase && apb_req_in.pwrite && mapped;
    end

    // Software strobes into the session control.
    always_comb begin
        arm_pulse = wr_commit && hit_ctrl && lane0 &&
                    apb_req_in.pwdata[ARM_BIT];
        disarm_sw = wr_commit && hit_ctrl && lane0 &&
                    !apb_req_in.pwdata[ARM_BIT];
        end_int   = evt_in.internal_end && armed_q;
    end

    // Session enable: software write wins over an internal end.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            armed_q <= 1'b0;
        end else if (arm_pulse) begin
            armed_q <= 1'b1;
        end else if (disarm_sw || end_int) begin
            armed_q <= 1'b0;
        end
    end

    // Trace-full flag lives on the power-on reset only, so that other
    // system resets keep the evidence of a filled buffer.
    // Full flag set; cleared by arming; POR only.
    sticky_bits #(
        .W (1)
    ) u_trace_full (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (por_n_in),
        .set_in     (evt_in.trace_filled && armed_q),
        .clr_in     (arm_pulse),
        .flags_out  (trace_full)
    );

    // Profiling flag follows the transmission, a late done loses to a
    // fresh entry in the same cycle.
    // Set on first entry; cleared at transmission end.
    sticky_bits #(
        .W (1)
    ) u_prof_active (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .set_in     (evt_in.prof_entry),
        .clr_in     (evt_in.prof_done),
        .flags_out  (prof_active)
    );

    // Event flags collect during a session and restart on arming.
    // External event; one bit per comparator.
    sticky_bits #(
        .W (HIT_W + 1)
    ) u_event_flags (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .set_in     ({evt_in.ext_event, evt_in.cmp_hit} &
                     {(HIT_W + 1){armed_q}}),
        .clr_in     ({(HIT_W + 1){arm_pulse}}),
        .flags_out  ({ext_flag, hit_flags})
    );

    // Sequencer state field tracker.
    seq_state_track u_seq (
        .clk_sys_in      (clk_sys_in),
        .rst_n_in        (rst_n_in),
        .arm_in          (arm_pulse),
        .armed_in        (armed_q),
        .internal_end_in (evt_in.internal_end),
        .step_in         (evt_in.seq_step),
        .state_in        (evt_in.seq_state),
        .field_out       (seq_field)
    );

    // Profiling end is seen as the done strobe while it was running.
    always_comb begin
        prof_done_evt = evt_in.prof_done && prof_active;
    end

    // Interrupt sources and their write-one-to-clear strobes.
    always_comb begin
        irq_set               = '0;
        irq_set[IRQ_FULL_BIT] = evt_in.trace_filled && armed_q;
        irq_set[IRQ_EXT_BIT]  = evt_in.ext_event && armed_q;
        irq_set[IRQ_END_BIT]  = end_int;
        irq_set[IRQ_PROF_BIT] = prof_done_evt;
        irq_clr = '0;
        if (wr_commit && hit_irq_st && lane0) begin
            irq_clr = apb_req_in.pwdata[IRQ_W-1:0];
        end
    end

    // Sticky interrupt status, set wins over a software clear.
    sticky_bits #(
        .W (IRQ_W)
    ) u_irq_status (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .set_in     (irq_set),
        .clr_in     (irq_clr),
        .flags_out  (irq_status)
    );

    // Interrupt mask register.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            irq_mask_q <= '0;
        end else if (wr_commit && hit_irq_mk && lane0) begin
            irq_mask_q <= apb_req_in.pwdata[IRQ_W-1:0];
        end
    end

    // Level interrupt while any unmasked status bit stands.
    assign irq_out = |(irq_status & irq_mask_q);

    // Valid line count: a full buffer makes the counter irrelevant.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            valid_lines_q <= '0;
        end else if (trace_full) begin
            valid_lines_q <= CNT_W'(LINES);
        end else begin
            valid_lines_q <= trace_line_counter_in;
        end
    end

    // Status and event bytes, unused positions tied low.
    always_comb begin
        status_word = REG_RST;
        status_word[TF_BIT] = trace_full;
        status_word[PA_BIT] = prof_active;
        status_word[SSF_LSB +: SSF_W] = seq_field;
        event_word = REG_RST;
        event_word[EEV_BIT] = ext_flag;
        event_word[HIT_LSB +: HIT_W] = hit_flags;
    end

    // Read multiplexer; status and event registers have no write path
    // at all, and reading them changes nothing.
    always_comb begin
        rdata_d = RDATA_RST;
        if (hit_ctrl) begin
            rdata_d[ARM_BIT] = armed_q;
        end else if (hit_irq_st) begin
            rdata_d[IRQ_W-1:0] = irq_status;
        end else if (hit_irq_mk) begin
            rdata_d[IRQ_W-1:0] = irq_mask_q;
        end else if (hit_event) begin
            rdata_d[7:0] = event_word;
        end else if (hit_status) begin
            rdata_d[7:0] = status_word;
        end
    end

    // Read data and error are captured in the setup cycle so they come
    // from flip-flops yet are ready in the access cycle with no wait.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rdata_q  <= RDATA_RST;
            slverr_q <= 1'b0;
        end else if (setup_phase) begin
            rdata_q  <= apb_req_in.pwrite ? RDATA_RST : rdata_d;
            slverr_q <= !mapped;
        end
    end

    // Answer: ready in every access cycle, error only for unmapped.
    always_comb begin
        apb_rsp_out.prdata  = rdata_q;
        apb_rsp_out.pready  = 1'b1;
        apb_rsp_out.pslverr = access_phase && slverr_q;
    end

    // Session outputs to the rest of the debug unit.
    assign armed_out       = armed_q;
    assign arm_pulse_out   = arm_pulse;
    assign valid_lines_out = valid_lines_q;

endmodule
`default_nettype wire

// [rtl/seq_state_track.sv]
// Tracker of the sequencer state field shown to software.
`timescale 1ns/1ps
`default_nettype none
module seq_state_track (
    // Clock and synchronous active-low reset.
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    // Session control.
    input  wire logic       arm_in,
    input  wire logic       armed_in,
    input  wire logic       internal_end_in,
    // State transitions reported by the sequencer.
    input  wire logic       step_in,
    input  wire logic [1:0] state_in,
    // Field value.
    output logic      [2:0] field_out
);
    import dbg_status_pkg::*;

    logic [SSF_W-1:0] field_q;  // Last state reached.

    // Arming beats an internal end, which beats a plain transition.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            field_q <= SEQ_S0;
        end else if (arm_in) begin
            field_q <= SEQ_S1;
        end else if (internal_end_in && armed_in) begin
            field_q <= SEQ_S0;
        end else if (step_in && armed_in) begin
            field_q <= {1'b0, state_in};
        end
        // Software disarm leaves the field untouched.
    end

    assign field_out = field_q;

endmodule
`default_nettype wire

// [rtl/sticky_bits.sv]
// Bank of sticky flags where a set always beats a clear.
`timescale 1ns/1ps
`default_nettype none
module sticky_bits #(
    parameter int unsigned W = 1
) (
    // Clock and synchronous active-low reset.
    input  wire logic         clk_sys_in,
    input  wire logic         rst_n_in,
    // Per-bit set and clear requests.
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] clr_in,
    // Current flag values.
    output logic      [W-1:0] flags_out
);

    logic [W-1:0] flags_q;  // Flag storage.
    logic [W-1:0] flags_d;  // Next flag value.

    // Set is ORed after the clear so a coincident event is never lost.
    always_comb begin
        flags_d = set_in | (flags_q & ~clr_in);
    end

    // The reset wired to this bank drops every flag to zero.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_out = flags_q;

endmodule
`default_nettype wire

// [verification/debug_session_status_checker.sv]
// Concurrent checks on the ports of the debug status block.
`timescale 1ns/1ps
`default_nettype none
module debug_session_status_checker #(
    parameter int unsigned LINES = 64
) (
    // Clock and resets.
    input  wire logic                     clk_sys_in,
    input  wire logic                     rst_n_in,
    input  wire logic                     por_n_in,
    // Bus and events.
    input  wire dbg_status_pkg::apb_req_s apb_req_in,
    input  wire dbg_status_pkg::apb_rsp_s apb_rsp_out,
    input  wire dbg_status_pkg::dbg_evt_s evt_in,
    input  wire logic [6:0]               trace_line_counter_in,
    // Status outputs.
    input  wire logic                     armed_out,
    input  wire logic                     arm_pulse_out,
    input  wire logic [6:0]               valid_lines_out,
    input  wire logic                     irq_out
);
    import dbg_status_pkg::*;
    // Line count shown while the buffer is full.
    localparam logic [6:0] FULL = 7'(LINES);
    // Access cycle of the bus, and a committing control write.
    wire logic acc = apb_req_in.psel && apb_req_in.penable;
    wire logic ctl_wr = acc && apb_req_in.pwrite && apb_req_in.pstrb[0]
        && (apb_req_in.paddr == ADDR_CTRL);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // A fill seen while armed, and a following cycle with no clear.
    // Power-on reset is excluded because it may clear the flag at once.
    sequence s_fill;
        evt_in.trace_filled && armed_out && por_n_in;
    endsequence
    sequence s_keep;
        !arm_pulse_out && por_n_in;
    endsequence
    // The slave never inserts wait states.
    a_pready_high: assert property (apb_rsp_out.pready)
        else $error("pready low");
    a_arm_cause: assert property (
        arm_pulse_out == (ctl_wr && apb_req_in.pwdata[ARM_BIT]))
        else $error("arm pulse without arming write");
    a_arm_sets: assert property (arm_pulse_out |=> armed_out)
        else $error("arming did not set enable");
    a_disarm_clears: assert property (
        ctl_wr && !apb_req_in.pwdata[ARM_BIT] |=> !armed_out)
        else $error("disarm write ignored");
    a_end_disarms: assert property (
        evt_in.internal_end && armed_out && !ctl_wr |=> !armed_out)
        else $error("internal end did not disarm");
    a_full_lines: assert property (s_fill ##1 s_keep |=>
        valid_lines_out == FULL)
        else $error("full buffer not reported as all lines");
    a_count_lines: assert property (
        $past(rst_n_in) && valid_lines_out != FULL
        |-> valid_lines_out == $past(trace_line_counter_in))
        else $error("valid lines differ from counter");
    a_err_access: assert property (apb_rsp_out.pslverr |-> acc)
        else $error("error outside access cycle");
    a_status_ok: assert property (
        acc && apb_req_in.paddr == ADDR_STATUS |-> !apb_rsp_out.pslverr)
        else $error("status access refused");
endmodule
bind debug_session_status debug_session_status_checker #(.LINES(LINES))
    debug_session_status_checker_i (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
    .apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out), .evt_in(evt_in),
    .trace_line_counter_in(trace_line_counter_in), .armed_out(armed_out),
    .arm_pulse_out(arm_pulse_out), .valid_lines_out(valid_lines_out),
    .irq_out(irq_out));
`default_nettype wire

// [verification/debug_session_status_tb_top.sv]
// Self-checking bench for the debug status block.
`timescale 1ns/1ps
`default_nettype none
module debug_session_status_tb_top;
    import dbg_status_pkg::*;
    localparam int LN = 64;        // Trace depth given to the design.
    logic       clk_sys_in = 1'b0; // Bench clock.
    logic       rst_n_in;          // System reset.
    logic       por_n_in;          // Power-on reset.
    apb_req_s   req;               // Bus request driven by the bench.
    apb_rsp_s   rsp;               // Bus answer.
    dbg_evt_s   evt;               // Event pulses.
    logic [6:0] cnt;               // Trace line counter.
    logic       armed;
    logic       arm_pulse;
    logic [6:0] vlines;
    logic       irq;
    logic [31:0] rd;               // Last read data.
    logic       err;               // Last error response.
    int         fail_count = 0;
    int         checks = 0;
    int         cycles = 0;
    integer     seed = 32'hd021;
    always #2.5 clk_sys_in = ~clk_sys_in;
    debug_session_status #(.LINES(LN)) debug_session_status_i (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
        .apb_req_in(req), .apb_rsp_out(rsp), .evt_in(evt),
        .trace_line_counter_in(cnt), .armed_out(armed),
        .arm_pulse_out(arm_pulse), .valid_lines_out(vlines),
        .irq_out(irq));
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // A hang is cut short well above the fewer than two hundred cycles needed.
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            finish_test();
        end
    end
    // Compares one value and counts the comparison.
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One bus transfer; the request is held until pready is sampled.
    // One idle edge follows the release, so that a second call never
    // drives the request twice in the same time step.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d,
                 pstrb:4'hf};
        @(posedge clk_sys_in);
        req.penable <= 1'b1;
        @(posedge clk_sys_in);
        while (rsp.pready !== 1'b1)
            @(posedge clk_sys_in);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clk_sys_in);
    endtask
    // Reads a register and compares the word.
    task automatic rchk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    // Drives one event pulse for a single cycle, then one quiet cycle so
    // that back-to-back pulses stay separate.
    task automatic pulse(input dbg_evt_s e);
        evt <= e;
        @(posedge clk_sys_in);
        evt <= '0;
        @(posedge clk_sys_in);
    endtask
    // Expected status word from its three fields.
    function automatic logic [31:0] st_exp(logic tf, logic pa,
                                           logic [2:0] sequencer_state_field);
        return {24'h0, tf, 2'b00, pa, 1'b0, sequencer_state_field};
    endfunction
    initial begin
        dbg_evt_s   e;
        logic [3:0] hits;
        logic [1:0] st;
        req = '0;
        evt = '0;
        cnt = '0;
        rst_n_in = 1'b0;
        por_n_in = 1'b0;
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        por_n_in <= 1'b1;
        @(posedge clk_sys_in);
        rchk("status", ADDR_STATUS, 32'h0);
        rchk("events", ADDR_EVENT, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        rchk("armed field", ADDR_STATUS, st_exp(0, 0, SEQ_S1));
        chk("armed", 32'h1, {31'h0, armed});
        $display("test reset and arm done");
        // First four steps visit every state code, then random ones.
        for (int i = 0; i < 10; i++) begin
            st = (i < 4) ? 2'(i) : 2'($random(seed));
            e = '0;
            e.seq_step = 1'b1;
            e.seq_state = st;
            pulse(e);
            rchk("ssf", ADDR_STATUS, st_exp(0, 0, {1'b0, st}));
        end
        $display("test sequencer done");
        hits = '0;
        for (int i = 0; i < 6; i++) begin
            e = '0;
            e.cmp_hit = 4'($random(seed));
            hits |= e.cmp_hit;
            pulse(e);
            rchk("hits", ADDR_EVENT, {28'h0, hits});
        end
        e = '0;
        e.ext_event = 1'b1;
        pulse(e);
        apb(1'b1, ADDR_EVENT, 32'h0);
        rchk("ext", ADDR_EVENT, {27'h0, 1'b1, hits});
        // External event is latched but masked until the mask is set.
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, ADDR_IRQ_MK, 32'h2);
        @(posedge clk_sys_in);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, ADDR_IRQ_ST, 32'h2);
        @(posedge clk_sys_in);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test event flags and interrupt done");
        cnt <= 7'($random(seed));
        e = '0;
        e.trace_filled = 1'b1;
        pulse(e);
        repeat (2) @(posedge clk_sys_in);
        chk("valid lines", 32'(LN), {25'h0, vlines});
        apb(1'b1, ADDR_STATUS, 32'hff);
        chk("status write err", 32'h0, {31'h0, err});
        rchk("full", ADDR_STATUS, st_exp(1, 0, {1'b0, st}));
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        rchk("full kept", ADDR_STATUS, st_exp(1, 0, SEQ_S0));
        apb(1'b1, ADDR_CTRL, 32'h1);
        rchk("rearm", ADDR_STATUS, st_exp(0, 0, SEQ_S1));
        pulse(e);
        por_n_in <= 1'b0;
        @(posedge clk_sys_in);
        por_n_in <= 1'b1;
        @(posedge clk_sys_in);
        rchk("por", ADDR_STATUS, st_exp(0, 0, SEQ_S1));
        $display("test trace full done");
        e = '0;
        e.prof_entry = 1'b1;
        pulse(e);
        rchk("prof on", ADDR_STATUS, st_exp(0, 1, SEQ_S1));
        e = '0;
        e.prof_done = 1'b1;
        pulse(e);
        rchk("prof off", ADDR_STATUS, st_exp(0, 0, SEQ_S1));
        e = '0;
        e.seq_step = 1'b1;
        e.seq_state = 2'h3;
        pulse(e);
        apb(1'b1, ADDR_CTRL, 32'h0);
        rchk("disarm", ADDR_STATUS, st_exp(0, 0, SEQ_S3));
        chk("disarmed", 32'h0, {31'h0, armed});
        apb(1'b1, ADDR_CTRL, 32'h1);
        e.seq_state = 2'h2;
        pulse(e);
        e = '0;
        e.internal_end = 1'b1;
        pulse(e);
        rchk("end", ADDR_STATUS, st_exp(0, 0, SEQ_S0));
        chk("ended", 32'h0, {31'h0, armed});
        $display("test profiling and session end done");
        rchk("unmapped", 12'h7fc, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        rchk("misaligned", 12'h401, 32'h0);
        chk("misaligned err", 32'h1, {31'h0, err});
        $display("test unmapped done");
        finish_test();
    end
endmodule
`default_nettype wire
